// *** logic/spim_top.sv ***
// serial port interrupt enable, disable and mask logic with status flags
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - writing one to enable-set bit sets that mask bit; zero leaves it
// - writing one to enable-clear bit clears that mask bit; zero does nothing
// - mask state register reads one for each enabled source
// - bits 0..7: tx ready, tx empty, tx end, tx buf empty, rx ready, overrun...
// - bits 8..11: compare0, compare1, tx sync, rx sync, each maskable alone
// - overrun sets when holding register reloads before the word or status was read
// - compare and sync flags set on event, clear on status read
// - rx buffer full is one only when both receive counters are zero
module spim_top (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // datapath events
    input wire spim_pkg::spim_evt_t i_evt,
    // interrupts
    output logic o_irq,
    output logic o_evt_irq
);
    logic [11:0] mask_reg;
    logic [11:0] flags;
    logic thr_full_reg;
    logic shift_busy_reg;
    logic tx_end_reg;
    logic rx_ready_reg;
    logic rx_unread_reg;
    logic overrun_reg;
    logic rx_end_reg;
    logic [3:0] evt_flag_reg;
    logic [11:0] evt_mask_reg;
    logic [11:0] evt_sticky;
    logic [11:0] evt_rise;
    logic [11:0] flags_d_reg;
    logic st_rd;
    logic wr_set;
    logic wr_clr;
    logic wr_eclr;
    logic [11:0] wbits;
    logic [3:0] evt_pulse;

    assign st_rd = i_rd && (i_addr == spim_pkg::OFF_STATUS);
    assign wr_set = i_wr && (i_addr == spim_pkg::OFF_IEN_SET);
    assign wr_clr = i_wr && (i_addr == spim_pkg::OFF_IEN_CLR);
    assign wr_eclr = i_wr && (i_addr == spim_pkg::OFF_EVT_STAT);
    assign wbits = i_wdata[11:0];
    assign evt_pulse = {i_evt.rx_sync, i_evt.tx_sync, i_evt.cmp1, i_evt.cmp0};

    // mask: set and clear registers only touch bits written as one
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mask_reg <= spim_pkg::MASK_RST;
        end else if (i_ce) begin
            if (wr_set) begin
                mask_reg <= mask_reg | wbits;
            end else if (wr_clr) begin
                mask_reg <= mask_reg & ~wbits;
            end
        end
    end

    // transmit holding register and shifter occupancy
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            thr_full_reg <= 1'b0;
            shift_busy_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_evt.thr_loaded) begin
                thr_full_reg <= 1'b1;
            end else if (i_evt.thr_to_shift) begin
                thr_full_reg <= 1'b0;
            end
            if (i_evt.thr_to_shift) begin
                shift_busy_reg <= 1'b1;
            end else if (i_evt.shift_idle) begin
                shift_busy_reg <= 1'b0;
            end
        end
    end

    // end of transfer flags: set at counter zero, cleared by a counter write
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tx_end_reg <= 1'b0;
            rx_end_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_evt.tx_cnt_wr) begin
                tx_end_reg <= 1'b0;
            end else if (i_evt.tx_cnt_zero) begin
                tx_end_reg <= 1'b1;
            end
            if (i_evt.rx_cnt_wr) begin
                rx_end_reg <= 1'b0;
            end else if (i_evt.rx_cnt_zero) begin
                rx_end_reg <= 1'b1;
            end
        end
    end

    // receive side: ready, unread tracking and overrun
    // unread is reset by a status read so a reload after that read is no overrun
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_ready_reg <= 1'b0;
            rx_unread_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_evt.rhr_load) begin
                rx_ready_reg <= 1'b1;
            end else if (i_evt.rhr_read) begin
                rx_ready_reg <= 1'b0;
            end
            if (i_evt.rhr_load) begin
                rx_unread_reg <= 1'b1;
            end else if (i_evt.rhr_read || st_rd) begin
                rx_unread_reg <= 1'b0;
            end
            if (i_evt.rhr_load && rx_unread_reg) begin
                overrun_reg <= 1'b1;
            end else if (st_rd) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    // compare and sync flags: set wins over the clearing status read
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            evt_flag_reg <= 4'h0;
        end else if (i_ce) begin
            evt_flag_reg <= (st_rd ? 4'h0 : evt_flag_reg) | evt_pulse;
        end
    end

    // flag vector in register order
    always_comb begin
        flags = 12'h000;
        flags[spim_pkg::BIT_TX_READY] = ~thr_full_reg;
        flags[spim_pkg::BIT_TX_EMPTY] = ~thr_full_reg & ~shift_busy_reg;
        flags[spim_pkg::BIT_TX_END] = tx_end_reg;
        flags[spim_pkg::BIT_TX_BUF_EMPTY] = i_evt.tx_cnt_zero & i_evt.tx_next_zero;
        flags[spim_pkg::BIT_RX_READY] = rx_ready_reg;
        flags[spim_pkg::BIT_RX_OVERRUN] = overrun_reg;
        flags[spim_pkg::BIT_RX_END] = rx_end_reg;
        flags[spim_pkg::BIT_RX_BUF_FULL] = i_evt.rx_cnt_zero & i_evt.rx_next_zero;
        flags[spim_pkg::BIT_RX_SYNC:spim_pkg::BIT_RX_CMP0] = evt_flag_reg;
    end

    // rising edges of flags feed the sticky event register
    // loaded with the live flags in reset: tx ready and tx empty idle high and
    // would otherwise show a false rising edge right after release
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            flags_d_reg <= flags;
        end else if (i_ce) begin
            flags_d_reg <= flags;
        end
    end
    assign evt_rise = flags & ~flags_d_reg;

    spim_sticky u_sticky (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_set(evt_rise),
        .i_clr(wr_eclr ? wbits : 12'h000),
        .o_q(evt_sticky)
    );

    // event mask shares the mask layout; written at the event status offset plus one word
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            evt_mask_reg <= spim_pkg::MASK_RST;
        end else if (i_ce && i_wr && i_addr == spim_pkg::OFF_EVT_STAT + 8'h04) begin
            evt_mask_reg <= wbits;
        end
    end

    // interrupt outputs registered: o_irq one cycle behind the flags, o_evt_irq one behind the sticky events
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_irq <= 1'b0;
            o_evt_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= |(flags & mask_reg);
            o_evt_irq <= |(evt_sticky & evt_mask_reg);
        end
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= spim_pkg::RDATA_RST;
        end else if (i_ce) begin
            o_rdata <= spim_pkg::RDATA_RST;
            if (i_rd) begin
                unique case (i_addr)
                    spim_pkg::OFF_STATUS: o_rdata <= {20'h00000, flags};
                    spim_pkg::OFF_MASK: o_rdata <= {20'h00000, mask_reg};
                    spim_pkg::OFF_EVT_STAT: o_rdata <= {20'h00000, evt_sticky};
                    spim_pkg::OFF_EVT_STAT + 8'h04: o_rdata <= {20'h00000, evt_mask_reg};
                    default: o_rdata <= spim_pkg::RDATA_RST;
                endcase
            end
        end
    end

    // checks
    // a write strobe to the enable-set address in an enabled cycle
    sequence s_set_wr;
        i_ce && wr_set;
    endsequence
    // a write strobe to the enable-clear address in an enabled cycle
    sequence s_clr_wr;
        i_ce && wr_clr;
    endsequence
    // a status read in an enabled cycle, which clears the read-sensitive flags
    sequence s_status_rd;
        i_ce && st_rd;
    endsequence
    // a receive load on top of a word that has not been read yet
    sequence s_load_unread;
        i_ce && i_evt.rhr_load && rx_unread_reg;
    endsequence

    // mask register: set, clear, hold and reset
    AST_SET_MASK: assert property (@(posedge i_clk) disable iff (i_srst)
        s_set_wr |=> ((mask_reg & $past(wbits)) == $past(wbits)))
        else $error("enable set did not set mask");
    AST_SET_KEEP: assert property (@(posedge i_clk) disable iff (i_srst)
        s_set_wr |=> ((mask_reg & ~$past(wbits)) == ($past(mask_reg) & ~$past(wbits))))
        else $error("enable set changed unwritten bits");
    AST_CLR_MASK: assert property (@(posedge i_clk) disable iff (i_srst)
        s_clr_wr |=> mask_reg == ($past(mask_reg) & ~$past(wbits)))
        else $error("enable clear wrong");
    AST_MASK_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && !wr_set && !wr_clr |=> mask_reg == $past(mask_reg))
        else $error("mask changed without a set or clear write");
    AST_MASK_RST: assert property (@(posedge i_clk)
        $past(i_srst) |-> mask_reg == spim_pkg::MASK_RST && !o_irq)
        else $error("mask or interrupt not cleared by reset");
    AST_FROZEN: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_ce |=> mask_reg == $past(mask_reg) && o_irq == $past(o_irq))
        else $error("state moved with the clock enable low");

    // read port: mask state and status bit placement
    AST_MASK_READ: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && i_rd && i_addr == spim_pkg::OFF_MASK && !i_wr
        |=> o_rdata == {20'h00000, $past(mask_reg)})
        else $error("mask read wrong");
    AST_RD_IDLE: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && !i_rd |=> o_rdata == spim_pkg::RDATA_RST)
        else $error("read data not zero outside a read");
    AST_ORDER: assert property (@(posedge i_clk) disable iff (i_srst)
        s_status_rd |=> o_rdata[spim_pkg::BIT_TX_READY] == !$past(thr_full_reg)
            && o_rdata[spim_pkg::BIT_RX_OVERRUN] == $past(overrun_reg))
        else $error("tx ready or overrun bit misplaced");
    AST_ORDER_HI: assert property (@(posedge i_clk) disable iff (i_srst)
        s_status_rd |=> o_rdata[spim_pkg::BIT_RX_SYNC:spim_pkg::BIT_RX_CMP0]
            == $past(evt_flag_reg))
        else $error("compare and sync bits misplaced");

    // compare, sync and overrun flags
    AST_CMP_ALONE: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && i_evt.cmp0 |=> flags[spim_pkg::BIT_RX_CMP0])
        else $error("compare 0 flag not set");
    AST_CMP1_ALONE: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && i_evt.cmp1 |=> flags[spim_pkg::BIT_RX_CMP1])
        else $error("compare 1 flag not set");
    AST_OVERRUN: assert property (@(posedge i_clk) disable iff (i_srst)
        s_load_unread |=> overrun_reg)
        else $error("overrun missed");
    AST_OVR_NONE: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && i_evt.rhr_load && !rx_unread_reg && !overrun_reg |=> !overrun_reg)
        else $error("overrun set on a load after a read");
    AST_OVR_CLR: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && st_rd && !i_evt.rhr_load |=> !overrun_reg)
        else $error("overrun not cleared by status read");
    AST_SYNC_CLR: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && st_rd && evt_pulse == 4'h0 |=> evt_flag_reg == 4'h0)
        else $error("sync flags not cleared by status read");
    AST_SYNC_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && !st_rd |=> (evt_flag_reg & $past(evt_flag_reg)) == $past(evt_flag_reg))
        else $error("compare or sync flag dropped without status read");
    AST_TX_SYNC: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && i_evt.tx_sync |=> flags[spim_pkg::BIT_TX_SYNC])
        else $error("tx sync flag not set");

    // transmit ready and receive buffer full
    AST_TX_READY_FLAG: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && i_evt.thr_loaded |=> !flags[spim_pkg::BIT_TX_READY])
        else $error("tx ready still high after load");
    AST_TX_READY_FLAG_FREE: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && i_evt.thr_to_shift && !i_evt.thr_loaded |=> flags[spim_pkg::BIT_TX_READY])
        else $error("tx ready low after move to shifter");
    AST_RX_BUFFER_FULL_FLAG: assert property (@(posedge i_clk) disable iff (i_srst)
        s_status_rd |=> o_rdata[spim_pkg::BIT_RX_BUF_FULL]
            == ($past(i_evt.rx_cnt_zero) && $past(i_evt.rx_next_zero)))
        else $error("rx buffer full read wrong");

    // interrupt output o_irq and sticky events
    AST_IRQ: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce |=> o_irq == |($past(flags) & $past(mask_reg)))
        else $error("irq mismatch");
    AST_EVT_KEEP: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && !wr_eclr |=> (evt_sticky & $past(evt_sticky)) == $past(evt_sticky))
        else $error("sticky event dropped without a clear write");
endmodule : spim_top

// *** logic/spim_pkg.sv ***
// package: register map, field positions and types for the serial port interrupt mask block
package spim_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NSRC = 12;
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_IEN_SET = 8'h04;
    localparam logic [7:0] OFF_IEN_CLR = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0c;
    localparam logic [7:0] OFF_EVT_STAT = 8'h10;
    // source bit positions
    localparam int BIT_TX_READY = 0;
    localparam int BIT_TX_EMPTY = 1;
    localparam int BIT_TX_END = 2;
    localparam int BIT_TX_BUF_EMPTY = 3;
    localparam int BIT_RX_READY = 4;
    localparam int BIT_RX_OVERRUN = 5;
    localparam int BIT_RX_END = 6;
    localparam int BIT_RX_BUF_FULL = 7;
    localparam int BIT_RX_CMP0 = 8;
    localparam int BIT_RX_CMP1 = 9;
    localparam int BIT_TX_SYNC = 10;
    localparam int BIT_RX_SYNC = 11;
    // reset values
    localparam logic [11:0] MASK_RST = 12'h000;
    localparam logic [11:0] FLAG_RST = 12'h000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // events from the serial controller's datapath
    typedef struct packed {
        logic thr_loaded;     // holding register written
        logic thr_to_shift;   // holding word moved to shift register
        logic shift_idle;     // shift register has sent its last bit
        logic tx_cnt_zero;    // transmit counter at zero
        logic tx_cnt_wr;      // transmit counter or next counter written
        logic tx_next_zero;   // transmit next counter at zero
        logic rhr_load;       // new word into receive holding register
        logic rhr_read;       // receive holding register read
        logic rx_cnt_zero;    // receive counter at zero
        logic rx_cnt_wr;      // receive counter or next counter written
        logic rx_next_zero;   // receive next counter at zero
        logic cmp0;           // compare 0 match
        logic cmp1;           // compare 1 match
        logic tx_sync;        // transmit sync seen
        logic rx_sync;        // receive sync seen
    } spim_evt_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } spim_bus_t;
endpackage : spim_pkg

// *** logic/spim_sticky.sv ***
// sticky event bits: set by a hardware pulse, cleared by writing one
`timescale 1ns/1ps
module spim_sticky (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // events and clears
    input wire logic [11:0] i_set,
    input wire logic [11:0] i_clr,
    // sticky state
    output logic [11:0] o_q
);
    // set beats clear so an event in the clearing cycle is not lost
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_q <= spim_pkg::FLAG_RST;
        end else if (i_ce) begin
            o_q <= (o_q & ~i_clr) | i_set;
        end
    end
endmodule : spim_sticky

// *** tb/test_serial_port_irq_mask.sv ***
// self-checking bench for the serial port interrupt mask block
`timescale 1ns/1ps
module test_serial_port_irq_mask;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_ce = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    spim_pkg::spim_evt_t evt = '0;
    logic o_irq;
    logic o_evt_irq;
    logic rd_q = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] care_q[$];
    logic [11:0] mdl;
    logic [31:0] rnd;
    int seed = 26538;
    int num_errors = 0;
    int cmp_count = 0;

    spim_top dut_u (
        .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(evt), .o_irq(o_irq),
        .o_evt_irq(o_evt_irq)
    );

    // 100 mhz clock
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    // one strobe cycle then one idle cycle, so no strobe is assigned twice at one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    // read: the expectation goes on the queue, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] c);
        exp_q.push_back(e & c);
        care_q.push_back(c);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
    endtask : rd

    // one-cycle event pulse on a bit of the packed event struct
    task automatic pulse(input int b);
        evt[b] <= 1'b1;
        @(posedge i_clk);
        evt[b] <= 1'b0;
        @(posedge i_clk);
    endtask : pulse

    // sample the registered interrupt after the edge has settled
    task automatic irq_is(input logic e);
        #1;
        check({31'h0, o_irq}, {31'h0, e}, "interrupt output");
    endtask : irq_is

    task automatic report_and_stop;
        $display("mismatches %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // read data stands only in the cycle after the strobe
    always @(posedge i_clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("wrong value at %0t ns: read data with no expectation", $time);
            end else begin
                check(o_rdata & care_q.pop_front(), exp_q.pop_front(), "read data");
            end
        end
        rd_q <= i_rd & i_ce;
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        num_errors++;
        report_and_stop;
    end

    initial begin
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        rd(spim_pkg::OFF_MASK, 32'h0, 32'hffff_ffff);
        rd(spim_pkg::OFF_STATUS, 32'h3, 32'hffff_ffff);
        wr(spim_pkg::OFF_IEN_SET, 32'h1);
        irq_is(1'b1);
        wr(spim_pkg::OFF_IEN_CLR, 32'h1);
        irq_is(1'b0);
        // transmit side flags
        pulse(14);
        rd(spim_pkg::OFF_STATUS, 32'h0, 32'h3);
        pulse(13);
        rd(spim_pkg::OFF_STATUS, 32'h1, 32'h3);
        pulse(12);
        rd(spim_pkg::OFF_STATUS, 32'h3, 32'h3);
        // overrun needs a second load before any read
        pulse(8);
        pulse(8);
        rd(spim_pkg::OFF_STATUS, 32'h30, 32'h30);
        rd(spim_pkg::OFF_STATUS, 32'h10, 32'h30);
        pulse(7);
        pulse(8);
        rd(spim_pkg::OFF_STATUS, 32'h10, 32'h30);
        // counter levels: one counter at zero is not enough for buffer flags
        evt[11] <= 1'b1;
        evt[6] <= 1'b1;
        repeat (2) @(posedge i_clk);
        rd(spim_pkg::OFF_STATUS, 32'h44, 32'hcc);
        evt[9] <= 1'b1;
        evt[4] <= 1'b1;
        repeat (2) @(posedge i_clk);
        rd(spim_pkg::OFF_STATUS, 32'hcc, 32'hcc);
        // compare and sync sources, event bits 3..0 map to status bits 8..11
        for (int k = 0; k < 4; k++) begin
            pulse(3 - k);
            irq_is(1'b0);
            wr(spim_pkg::OFF_IEN_SET, 32'h1 << (8 + k));
            irq_is(1'b1);
            rd(spim_pkg::OFF_STATUS, 32'h1 << (8 + k), 32'hf00);
            rd(spim_pkg::OFF_STATUS, 32'h0, 32'hf00);
            irq_is(1'b0);
            wr(spim_pkg::OFF_IEN_CLR, 32'h1 << (8 + k));
        end
        // sticky event register, its mask and the second interrupt
        wr(8'h14, 32'h100);
        rd(8'h14, 32'h100, 32'hffff_ffff);
        wr(spim_pkg::OFF_EVT_STAT, 32'hfff);
        #1;
        check({31'h0, o_evt_irq}, 32'h0, "event interrupt");
        pulse(3);
        @(posedge i_clk);
        #1;
        check({31'h0, o_evt_irq}, 32'h1, "event interrupt");
        wr(spim_pkg::OFF_EVT_STAT, 32'h100);
        #1;
        check({31'h0, o_evt_irq}, 32'h0, "event interrupt");
        wr(8'h14, 32'h0);
        // refused accesses and a write with the clock enable low
        rd(8'h40, 32'h0, 32'hffff_ffff);
        wr(spim_pkg::OFF_MASK, 32'hfff);
        i_ce <= 1'b0;
        wr(spim_pkg::OFF_IEN_SET, 32'hfff);
        i_ce <= 1'b1;
        rd(spim_pkg::OFF_MASK, 32'h0, 32'hffff_ffff);
        // random set and clear patterns against a mask model
        mdl = 12'h000;
        for (int i = 0; i < 16; i++) begin
            rnd = $random(seed);
            wr(spim_pkg::OFF_IEN_SET, rnd);
            mdl = mdl | rnd[11:0];
            rd(spim_pkg::OFF_MASK, {20'h0, mdl}, 32'hffff_ffff);
            rnd = $random(seed);
            wr(spim_pkg::OFF_IEN_CLR, rnd);
            mdl = mdl & ~rnd[11:0];
            rd(spim_pkg::OFF_MASK, {20'h0, mdl}, 32'hffff_ffff);
        end
        // second reset in mid-run: mask, sticky events and interrupt clear again
        wr(spim_pkg::OFF_IEN_SET, 32'hfff);
        i_srst <= 1'b1;
        evt <= '0;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        rd(spim_pkg::OFF_MASK, 32'h0, 32'hffff_ffff);
        rd(spim_pkg::OFF_STATUS, 32'h3, 32'hffff_ffff);
        rd(spim_pkg::OFF_EVT_STAT, 32'h0, 32'hffff_ffff);
        irq_is(1'b0);
        repeat (2) @(posedge i_clk);
        report_and_stop;
    end
endmodule : test_serial_port_irq_mask
